// ### testbench/edc_far_model.sv
// far side of the transfer engine: dual-port RAM and peripheral registers
// assumes the engine's clock; read data is due the cycle after the strobe
`timescale 1ns/100ps
module edc_far_model (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic stall_i,
	input wire logic ram_rd_i,
	input wire logic per_rd_i,
	input wire logic [15:0] rd_addr_i,
	output logic [15:0] ram_rdata_o,
	output logic [15:0] per_rdata_o,
	input wire logic ram_wr_i,
	input wire logic per_wr_i,
	input wire logic [15:0] wr_addr_i,
	input wire logic [15:0] wr_data_i,
	input wire logic wr_byte_i,
	output logic ram_wr_rdy_o,
	output logic per_wr_rdy_o,
	output logic [15:0] n_wr_o,
	output logic [15:0] last_addr_o,
	output logic [15:0] last_data_o,
	output logic last_byte_o,
	output logic last_per_o
);
	logic ram_q;
	logic per_q;
	logic [15:0] val;
	// buffers live in RAM, content is address-derived
	// outside the answer cycle the lines show the inverse
	assign ram_rdata_o = ram_q ? val : ~val;
	assign per_rdata_o = per_q ? val : ~val;
	assign ram_wr_rdy_o = !stall_i;
	assign per_wr_rdy_o = !stall_i;
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ram_q <= 1'b0;
			per_q <= 1'b0;
			val <= 16'h0000;
			n_wr_o <= 16'h0000;
		end else begin
			ram_q <= ram_rd_i;
			per_q <= per_rd_i;
			if (ram_rd_i)
				val <= rd_addr_i ^ 16'hA5A5;
			else if (per_rd_i)
				val <= rd_addr_i ^ 16'h5A00;
			if ((ram_wr_i && !stall_i) || (per_wr_i && !stall_i)) begin
				n_wr_o <= n_wr_o + 16'h0001;
				last_addr_o <= wr_addr_i;
				last_data_o <= wr_data_i;
				last_byte_o <= wr_byte_i;
				last_per_o <= per_wr_i;
			end
		end
	end
endmodule : edc_far_model

// ### testbench/tb_eight_channel_dma_controller.sv
// self-checking bench of the eight-channel transfer engine
// assumes edc_far_model as RAM and peripherals, registers as plain ports
`timescale 1ns/100ps
`include "edc_params.svh"
module tb_eight_channel_dma_controller;
	localparam logic [6:0] CODES [17] = '{`EDC_RQ_EXT0, `EDC_RQ_CAP1, `EDC_RQ_CMP1,
		`EDC_RQ_CAP2, `EDC_RQ_CMP2, `EDC_RQ_TMR2, `EDC_RQ_TMR3, `EDC_RQ_SPI1,
		`EDC_RQ_SER1_RX, `EDC_RQ_SER1_TX, `EDC_RQ_ADC, `EDC_RQ_SER2_RX,
		`EDC_RQ_SER2_TX, `EDC_RQ_SPI2, `EDC_RQ_CAN_RX, `EDC_RQ_PAR, `EDC_RQ_CAN_TX};
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic reg_wr_i = 1'b0;
	logic [2:0] reg_ch_i = 3'h0;
	logic [2:0] reg_sel_i = 3'h0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic [15:0] reg_rdata_o;
	logic [127:0] irq_src_i = '0;
	logic [15:0] per_ind_ofs_i = 16'h0010;
	logic [15:0] rd_addr_o, ram_rdata_i, per_rdata_i, wr_addr_o, wr_data_o;
	logic ram_rd_o, per_rd_o, wr_byte_o, ram_wr_o, per_wr_o, busy_o;
	logic ram_wr_rdy_i, per_wr_rdy_i;
	logic cpu_ram_wr_i = 1'b0;
	logic cpu_per_wr_i = 1'b0;
	logic [15:0] cpu_per_addr_i = 16'h0000;
	logic clk_en = 1'b1;
	logic [15:0] cpu_ram_addr_i = 16'h0000;
	logic [7:0] ch_irq_o;
	logic stall = 1'b0;
	logic [15:0] n_wr, l_addr, l_data;
	logic l_byte, l_per;
	logic [7:0] irq_cnt [8] = '{default: 8'h00};
	int n_fail = 0;
	int checks = 0;
	logic [15:0] nw = 16'h0000;
	edc_dma_top #(.NCH(8), .DEPTH(2)) dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.clk_en_i(clk_en), .reg_wr_i(reg_wr_i), .reg_ch_i(reg_ch_i), .reg_sel_i(reg_sel_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .irq_src_i(irq_src_i),
		.per_ind_ofs_i(per_ind_ofs_i), .rd_addr_o(rd_addr_o), .ram_rd_o(ram_rd_o),
		.per_rd_o(per_rd_o), .ram_rdata_i(ram_rdata_i), .per_rdata_i(per_rdata_i),
		.wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_byte_o(wr_byte_o),
		.ram_wr_o(ram_wr_o), .per_wr_o(per_wr_o), .ram_wr_rdy_i(ram_wr_rdy_i),
		.per_wr_rdy_i(per_wr_rdy_i), .cpu_ram_wr_i(cpu_ram_wr_i),
		.cpu_ram_addr_i(cpu_ram_addr_i), .cpu_per_wr_i(cpu_per_wr_i),
		.cpu_per_addr_i(cpu_per_addr_i),
		.ch_irq_o(ch_irq_o), .busy_o(busy_o));
	edc_far_model far_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .stall_i(stall),
		.ram_rd_i(ram_rd_o), .per_rd_i(per_rd_o), .rd_addr_i(rd_addr_o),
		.ram_rdata_o(ram_rdata_i), .per_rdata_o(per_rdata_i), .ram_wr_i(ram_wr_o),
		.per_wr_i(per_wr_o), .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o),
		.wr_byte_i(wr_byte_o), .ram_wr_rdy_o(ram_wr_rdy_i), .per_wr_rdy_o(per_wr_rdy_i),
		.n_wr_o(n_wr), .last_addr_o(l_addr), .last_data_o(l_data), .last_byte_o(l_byte),
		.last_per_o(l_per));
	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		for (int i = 0; i < 8; i++)
			if (ch_irq_o[i] === 1'b1)
				irq_cnt[i] <= irq_cnt[i] + 8'h01;
	end
	function automatic logic [15:0] con(logic byt, logic dir, logic half, logic [1:0] am,
		logic [1:0] md);
		return {1'b1, byt, dir, half, 6'h00, am, 2'h0, md};
	endfunction : con
	task automatic end_of_test();
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [2:0] ch, input logic [2:0] sel, input logic [15:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_ch_i <= ch;
		reg_sel_i <= sel;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] ch, input logic [2:0] sel, output logic [15:0] v);
		@(posedge sys_clk_i);
		reg_ch_i <= ch;
		reg_sel_i <= sel;
		repeat (2) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		v = reg_rdata_o;
	endtask : rd
	task automatic cfg(input logic [2:0] ch, input logic [15:0] req, input logic [15:0] pri,
		input logic [15:0] sec, input logic [15:0] pad, input logic [15:0] cnt,
		input logic [15:0] c);
		wr(ch, `EDC_SEL_REQ, req);
		wr(ch, `EDC_SEL_PRI, pri);
		wr(ch, `EDC_SEL_SEC, sec);
		wr(ch, `EDC_SEL_PAD, pad);
		wr(ch, `EDC_SEL_CNT, cnt);
		wr(ch, `EDC_SEL_CON, c);
	endtask : cfg
	task automatic pulse(input logic [6:0] code);
		@(posedge sys_clk_i);
		irq_src_i[code] <= 1'b1;
		@(posedge sys_clk_i);
		irq_src_i[code] <= 1'b0;
	endtask : pulse
	task automatic wait_wr(input int k);
		int t;
		t = 0;
		nw = nw + 16'(k);
		while (n_wr !== nw && t < 200) begin
			@(negedge sys_clk_i);
			t++;
		end
		chk("write count", n_wr, nw);
	endtask : wait_wr
	task automatic t_regs();
		logic [15:0] v;
		rd(3'h7, `EDC_SEL_CNT, v);
		chk("count reset", v, 16'h0000);
		wr(3'h7, `EDC_SEL_CON, 16'hFFFF);
		rd(3'h7, `EDC_SEL_CON, v);
		chk("control mask", v, 16'hF833);
		wr(3'h7, `EDC_SEL_CON, 16'h0000);
		wr(3'h7, `EDC_SEL_CNT, 16'hFFFF);
		rd(3'h7, `EDC_SEL_CNT, v);
		chk("count width", v, 16'h03FF);
		@(posedge sys_clk_i);
		clk_en <= 1'b0;
		wr(3'h7, `EDC_SEL_CNT, 16'h0000);
		clk_en <= 1'b1;
		rd(3'h7, `EDC_SEL_CNT, v);
		chk("frozen write", v, 16'h03FF);
		for (int c = 0; c < 8; c++)
			wr(3'(c), `EDC_SEL_PAD, 16'h0240 + 16'(c));
		for (int c = 0; c < 8; c++) begin
			rd(3'(c), `EDC_SEL_PAD, v);
			chk("own pad", v, 16'h0240 + 16'(c));
		end
	endtask : t_regs
	task automatic t_modes();
		logic [15:0] v;
		logic [15:0] a1;
		logic [15:0] a2;
		for (int am = 0; am < 3; am++) begin
			a1 = (am == 2) ? 16'h0810 : 16'h0800;
			a2 = (am == 0) ? 16'h0802 : a1;
			cfg(3'h2, {9'h100, `EDC_RQ_CAP1}, 16'h0800, 16'h0000, 16'h0140, 16'h0001,
				16'h0000);
			wr(3'h2, `EDC_SEL_REQ, {9'h000, `EDC_RQ_CAP1});
			rd(3'h2, `EDC_SEL_REQ, v);
			chk("force kept", v, {9'h100, `EDC_RQ_CAP1});
			wr(3'h2, `EDC_SEL_CON, con(1'b0, 1'b0, 1'b0, 2'(am), 2'h1));
			wait_wr(1);
			chk("addr 1", l_addr, a1);
			chk("data", l_data, 16'h5B40);
			rd(3'h2, `EDC_SEL_PRI, v);
			chk("pointer", v, (am == 0) ? 16'h0802 : 16'h0800);
			rd(3'h2, `EDC_SEL_REQ, v);
			chk("force done", v, {9'h000, `EDC_RQ_CAP1});
			pulse(`EDC_RQ_CAP1);
			wait_wr(1);
			chk("addr 2", l_addr, a2);
			rd(3'h2, `EDC_SEL_CON, v);
			chk("one-shot stop", v & 16'h8000, 16'h0000);
			rd(3'h2, `EDC_SEL_SEC, v);
			chk("pointer home", v, 16'h0800);
			chk("block irq", {8'h00, irq_cnt[2]}, 16'(am + 1));
		end
	endtask : t_modes
	task automatic t_byte();
		cfg(3'h5, {9'h000, `EDC_RQ_SER1_TX}, 16'h0901, 16'h0000, 16'h0224, 16'h0000,
			con(1'b1, 1'b1, 1'b0, 2'h0, 2'h1));
		pulse(`EDC_RQ_SER1_TX);
		wait_wr(1);
		chk("to periph", {15'h0000, l_per}, 16'h0001);
		chk("byte addr", l_addr, 16'h0224);
		chk("byte data", l_data, 16'h00A4);
		chk("byte flag", {15'h0000, l_byte}, 16'h0001);
	endtask : t_byte
	task automatic t_prio();
		logic [15:0] v;
		cfg(3'h6, {9'h000, `EDC_RQ_TMR2}, 16'h0C00, 16'h0000, 16'h0180, 16'h0000,
			con(1'b0, 1'b1, 1'b0, 2'h0, 2'h0));
		cfg(3'h1, {9'h000, `EDC_RQ_TMR2}, 16'h0A00, 16'h0000, 16'h0182, 16'h0000,
			con(1'b0, 1'b1, 1'b0, 2'h0, 2'h0));
		stall <= 1'b1;
		pulse(`EDC_RQ_TMR2);
		repeat (8) @(posedge sys_clk_i);
		cpu_per_wr_i <= 1'b1;
		cpu_per_addr_i <= 16'h0182;
		@(posedge sys_clk_i);
		cpu_per_wr_i <= 1'b0;
		stall <= 1'b0;
		wait_wr(1);
		chk("first grant", l_addr, 16'h0182);
		wait_wr(1);
		chk("second grant", l_addr, 16'h0180);
		chk("second data", l_data, 16'hA9A5);
		rd(3'h0, `EDC_SEL_COL, v);
		chk("periph collision", v, 16'h0200);
		wr(3'h0, `EDC_SEL_COL, 16'h0000);
		wr(3'h1, `EDC_SEL_CON, 16'h0000);
		wr(3'h6, `EDC_SEL_CON, 16'h0000);
	endtask : t_prio
	task automatic t_half();
		logic [15:0] v;
		cfg(3'h4, {9'h000, `EDC_RQ_ADC}, 16'h0400, 16'h0000, 16'h0300, 16'h0003,
			con(1'b0, 1'b0, 1'b1, 2'h0, 2'h1));
		for (int i = 1; i < 5; i++) begin
			pulse(`EDC_RQ_ADC);
			wait_wr(1);
			chk("half addr", l_addr, 16'h0400 + 16'(2 * (i - 1)));
			rd(3'h4, `EDC_SEL_CON, v);
			chk("half irq", {8'h00, irq_cnt[4]}, (i >= 2) ? 16'h0001 : 16'h0000);
			chk("block length", v & 16'h8000, (i == 4) ? 16'h0000 : 16'h8000);
		end
	endtask : t_half
	task automatic t_codes();
		cfg(3'h0, {9'h000, CODES[0]}, 16'h0600, 16'h0700, 16'h0226, 16'h0000,
			con(1'b0, 1'b0, 1'b0, 2'h0, 2'h2));
		for (int i = 0; i < 17; i++) begin
			wr(3'h0, `EDC_SEL_REQ, {9'h000, CODES[i]});
			pulse(CODES[i]);
			wait_wr(1);
			chk("ping-pong", l_addr, i[0] ? 16'h0700 : 16'h0600);
		end
	endtask : t_codes
	task automatic t_stall();
		logic [15:0] v;
		wr(3'h0, `EDC_SEL_CON, 16'h0000);
		wr(3'h0, `EDC_SEL_CON, con(1'b0, 1'b0, 1'b0, 2'h0, 2'h0));
		stall <= 1'b1;
		repeat (3) begin
			pulse(`EDC_RQ_CAN_TX);
			repeat (4) @(posedge sys_clk_i);
		end
		cpu_ram_wr_i <= 1'b1;
		cpu_ram_addr_i <= 16'h0600;
		@(posedge sys_clk_i);
		cpu_ram_wr_i <= 1'b0;
		@(negedge sys_clk_i);
		chk("held write", {14'h0000, ram_wr_o, busy_o}, 16'h0003);
		@(posedge sys_clk_i);
		stall <= 1'b0;
		wait_wr(3);
		chk("drained addr", l_addr, 16'h0600);
		rd(3'h0, `EDC_SEL_COL, v);
		chk("collision", v, 16'h0001);
		wr(3'h0, `EDC_SEL_COL, 16'h0000);
		rd(3'h0, `EDC_SEL_COL, v);
		chk("collision clr", v, 16'h0000);
	endtask : t_stall
	initial begin
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		t_regs();
		t_modes();
		t_byte();
		t_prio();
		t_half();
		t_codes();
		t_stall();
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_fail++;
		end_of_test();
	end
endmodule : tb_eight_channel_dma_controller

// ### verilog/edc_arb.sv
// fixed priority arbiter, lowest index wins
// assumes requests settle within the cycle
`timescale 1ns/100ps
module edc_arb #(
	parameter int N = 8
) (
	input wire logic [N-1:0] req_i,
	output logic [N-1:0] gnt_o,
	output logic [$clog2(N)-1:0] idx_o,
	output logic any_o
);
	function automatic logic [$clog2(N)-1:0] f_lowest(input logic [N-1:0] r);
		logic [$clog2(N)-1:0] k;
		k = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (r[i]) begin
				k = i[$clog2(N)-1:0];
			end
		end
		return k;
	endfunction : f_lowest

	always_comb begin
		idx_o = f_lowest(req_i);
		any_o = |req_i;
		gnt_o = '0;
		if (any_o) begin
			gnt_o[idx_o] = 1'b1;
		end
	end
endmodule : edc_arb

// ### verilog/edc_buf.sv
// small valid/ready buffer between read and write phases
// assumes synchronous reset copy and a shared clock enable
`timescale 1ns/100ps
module edc_buf #(
	parameter int W = 37,
	parameter int DEPTH = 2
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	edc_stream_if.snk in_if,
	edc_stream_if.src out_if
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [W-1:0] mem_ff [DEPTH];
	logic [W-1:0] nxt_mem [DEPTH];
	logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic push, pop;

	function automatic logic [AW-1:0] f_inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : f_inc

	assign in_if.ready = (cnt_ff != CW'(DEPTH));
	assign out_if.valid = (cnt_ff != '0);
	assign out_if.data = mem_ff[rp_ff];
	assign push = in_if.valid && in_if.ready;
	assign pop = out_if.valid && out_if.ready;

	always_comb begin
		nxt_mem = mem_ff;
		nxt_wp = wp_ff;
		nxt_rp = rp_ff;
		nxt_cnt = cnt_ff;
		if (push) begin
			nxt_mem[wp_ff] = in_if.data;
			nxt_wp = f_inc(wp_ff);
		end
		if (pop) begin
			nxt_rp = f_inc(rp_ff);
		end
		if (push && !pop) begin
			nxt_cnt = CW'(cnt_ff + 1'b1);
		end else if (pop && !push) begin
			nxt_cnt = CW'(cnt_ff - 1'b1);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= '0;
			end
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else if (clk_en_i) begin
			mem_ff <= nxt_mem;
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
			cnt_ff <= nxt_cnt;
		end
	end

	chk_buf_hold_stall: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(out_if.valid && !out_if.ready) |=> out_if.valid && $stable(out_if.data))
		else $error("stalled word lost or changed");
endmodule : edc_buf

// ### verilog/edc_dma_top.sv
// eight-channel transfer engine between peripheral registers and dual-port RAM
// assumes peripherals, RAM and register port all run on sys_clk_i
`timescale 1ns/100ps
`include "edc_params.svh"

module edc_dma_top #(
	parameter int NCH = `EDC_NUM_CH,
	parameter int DEPTH = 2
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	input wire logic reg_wr_i,
	input wire logic [2:0] reg_ch_i,
	input wire logic [2:0] reg_sel_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	input wire logic [`EDC_SRC_NUM-1:0] irq_src_i,
	input wire logic [15:0] per_ind_ofs_i,
	output logic [15:0] rd_addr_o,
	output logic ram_rd_o,
	output logic per_rd_o,
	input wire logic [15:0] ram_rdata_i,
	input wire logic [15:0] per_rdata_i,
	output logic [15:0] wr_addr_o,
	output logic [15:0] wr_data_o,
	output logic wr_byte_o,
	output logic ram_wr_o,
	output logic per_wr_o,
	input wire logic ram_wr_rdy_i,
	input wire logic per_wr_rdy_i,
	input wire logic cpu_ram_wr_i,
	input wire logic [15:0] cpu_ram_addr_i,
	input wire logic cpu_per_wr_i,
	input wire logic [15:0] cpu_per_addr_i,
	output logic [NCH-1:0] ch_irq_o,
	output logic busy_o
);
	import edc_pkg::*;
	localparam int XW = $bits(edc_xfer_t);

	logic [1:0] rs_ff;
	logic rst_s;
	logic [15:0] con_ff [NCH], nxt_con [NCH];
	logic [6:0] sel_ff [NCH], nxt_sel [NCH];
	logic [15:0] pri_ff [NCH], nxt_pri [NCH], sec_ff [NCH], nxt_sec [NCH];
	logic [15:0] pad_ff [NCH], nxt_pad [NCH], ptr_ff [NCH], nxt_ptr [NCH];
	logic [9:0] cnt_ff [NCH], nxt_cnt [NCH], idx_ff [NCH], nxt_idx [NCH];
	logic [NCH-1:0] frc_ff, nxt_frc, pend_ff, nxt_pend, pp_ff, nxt_pp, irq_ff, nxt_irq;
	logic [NCH-1:0] req, gnt;
	logic [15:0] col_ff, nxt_col, rdata_ff, nxt_rdata;
	edc_state_t st_ff, nxt_st;
	logic [2:0] ch_ff, nxt_ch, gidx, last_ff, nxt_last;
	logic [15:0] rda_ff, nxt_rda, dst_ff, nxt_dst, ram_a, cap;
	logic rdper_ff, nxt_rdper, any;
	logic [10:0] idx_inc, tot, half_pt;
	logic blk_end, half_hit;
	edc_xfer_t push_x, out_x;

	edc_stream_if #(.W(XW)) b_in ();
	edc_stream_if #(.W(XW)) b_out ();

	function automatic logic [15:0] f_start(input logic pp, input logic [15:0] a,
		input logic [15:0] b);
		return pp ? b : a;
	endfunction : f_start

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rs_ff <= 2'h0;
		end else if (clk_en_i) begin
			rs_ff <= {rs_ff[0], 1'b1};
		end
	end
	assign rst_s = rs_ff[1];

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			req[i] = con_ff[i][`EDC_CON_EN] && (pend_ff[i] || frc_ff[i]);
		end
	end

	edc_arb #(.N(NCH)) u_arb (
		.req_i(req),
		.gnt_o(gnt),
		.idx_o(gidx),
		.any_o(any)
	);

	// ram address of the granted channel, peripheral may supply an offset
	assign ram_a = con_ff[gidx][`EDC_CON_AM_HI] ? 16'(ptr_ff[gidx] + per_ind_ofs_i)
		: ptr_ff[gidx];

	always_comb begin
		nxt_st = st_ff;
		nxt_ch = ch_ff;
		nxt_rda = rda_ff;
		nxt_dst = dst_ff;
		nxt_rdper = rdper_ff;
		nxt_last = last_ff;
		case (st_ff)
			st_idle: begin
				if (any && b_in.ready) begin
					nxt_st = st_read;
					nxt_ch = gidx;
					nxt_last = gidx;
					nxt_rdper = !con_ff[gidx][`EDC_CON_DIR];
					nxt_rda = con_ff[gidx][`EDC_CON_DIR] ? ram_a : pad_ff[gidx];
					nxt_dst = con_ff[gidx][`EDC_CON_DIR] ? pad_ff[gidx] : ram_a;
				end
			end
			st_read: begin
				nxt_st = st_push;
			end
			st_push: begin
				nxt_st = st_idle;
			end
			default: begin
				nxt_st = st_idle;
			end
		endcase
	end

	// dedicated transfer bus, separate from the processor's
	assign rd_addr_o = rda_ff;
	assign ram_rd_o = (st_ff == st_read) && !rdper_ff;
	assign per_rd_o = (st_ff == st_read) && rdper_ff;
	assign cap = rdper_ff ? per_rdata_i : ram_rdata_i;

	assign idx_inc = 11'({1'b0, idx_ff[ch_ff]} + 11'h001);
	assign tot = 11'({1'b0, cnt_ff[ch_ff]} + 11'h001);
	assign half_pt = 11'((tot + 11'h001) >> 1);
	assign blk_end = (idx_inc == tot);
	assign half_hit = (idx_inc == half_pt);

	always_comb begin
		push_x.ch = ch_ff;
		push_x.to_per = con_ff[ch_ff][`EDC_CON_DIR];
		push_x.byte_sz = con_ff[ch_ff][`EDC_CON_BYTE];
		push_x.addr = dst_ff;
		push_x.data = con_ff[ch_ff][`EDC_CON_BYTE] ? (cap & `EDC_LOW_BYTE) : cap;
	end
	assign b_in.valid = (st_ff == st_push);
	assign b_in.data = push_x;

	edc_buf #(.W(XW), .DEPTH(DEPTH)) u_buf (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_s),
		.clk_en_i(clk_en_i),
		.in_if(b_in),
		.out_if(b_out)
	);

	assign out_x = b_out.data;
	assign wr_addr_o = out_x.addr;
	assign wr_data_o = out_x.data;
	assign wr_byte_o = out_x.byte_sz;
	assign ram_wr_o = b_out.valid && !out_x.to_per;
	assign per_wr_o = b_out.valid && out_x.to_per;
	assign b_out.ready = out_x.to_per ? per_wr_rdy_i : ram_wr_rdy_i;

	always_comb begin
		logic [15:0] step;
		logic [15:0] wv;
		logic pp_n;
		logic [2:0] c;
		step = `EDC_STEP_WORD;
		wv = reg_wdata_i;
		pp_n = 1'b0;
		c = ch_ff;
		nxt_con = con_ff;
		nxt_sel = sel_ff;
		nxt_pri = pri_ff;
		nxt_sec = sec_ff;
		nxt_pad = pad_ff;
		nxt_cnt = cnt_ff;
		nxt_ptr = ptr_ff;
		nxt_idx = idx_ff;
		nxt_frc = frc_ff;
		nxt_pp = pp_ff;
		nxt_irq = '0;
		nxt_pend = pend_ff;
		nxt_col = col_ff;
		if (st_ff == st_idle && any && b_in.ready) begin
			nxt_pend[gidx] = 1'b0;
		end
		for (int i = 0; i < NCH; i++) begin
			if (con_ff[i][`EDC_CON_EN] && irq_src_i[sel_ff[i]]) begin
				nxt_pend[i] = 1'b1;
			end
		end
		if (st_ff == st_push) begin
			step = con_ff[c][`EDC_CON_BYTE] ? `EDC_STEP_BYTE : `EDC_STEP_WORD;
			nxt_frc[c] = 1'b0;
			nxt_irq[c] = con_ff[c][`EDC_CON_HALF] ? half_hit : blk_end;
			nxt_idx[c] = idx_inc[9:0];
			if (con_ff[c][`EDC_CON_AM_HI:`EDC_CON_AM_LO] == 2'h0) begin
				nxt_ptr[c] = 16'(ptr_ff[c] + step);
			end
			if (blk_end) begin
				pp_n = con_ff[c][`EDC_CON_PP] ? !pp_ff[c] : pp_ff[c];
				nxt_pp[c] = pp_n;
				nxt_idx[c] = '0;
				nxt_ptr[c] = f_start(pp_n, pri_ff[c], sec_ff[c]);
				if (con_ff[c][`EDC_CON_ONE] && (!con_ff[c][`EDC_CON_PP] || pp_ff[c])) begin
					nxt_con[c][`EDC_CON_EN] = 1'b0;
				end
			end
		end
		if (reg_wr_i) begin
			if (reg_sel_i == `EDC_SEL_CON) begin
				nxt_con[reg_ch_i] = wv & `EDC_CON_MASK;
				if (wv[`EDC_CON_EN] && !con_ff[reg_ch_i][`EDC_CON_EN]) begin
					nxt_ptr[reg_ch_i] = pri_ff[reg_ch_i];
					nxt_idx[reg_ch_i] = '0;
					nxt_pp[reg_ch_i] = 1'b0;
				end
			end else if (reg_sel_i == `EDC_SEL_REQ) begin
				nxt_sel[reg_ch_i] = wv[6:0];
				nxt_frc[reg_ch_i] = frc_ff[reg_ch_i] | wv[`EDC_REQ_FORCE];
			end else if (reg_sel_i == `EDC_SEL_PRI) begin
				nxt_pri[reg_ch_i] = wv;
			end else if (reg_sel_i == `EDC_SEL_SEC) begin
				nxt_sec[reg_ch_i] = wv;
			end else if (reg_sel_i == `EDC_SEL_PAD) begin
				nxt_pad[reg_ch_i] = wv;
			end else if (reg_sel_i == `EDC_SEL_CNT) begin
				nxt_cnt[reg_ch_i] = wv[9:0];
			end else if (reg_sel_i == `EDC_SEL_COL) begin
				// a zero clears; collisions are applied below, so set wins
				nxt_col = col_ff & wv;
			end
		end
		if (ram_wr_o && cpu_ram_wr_i && cpu_ram_addr_i == out_x.addr) begin
			nxt_col[out_x.ch] = 1'b1;
		end
		if (per_wr_o && cpu_per_wr_i && cpu_per_addr_i == out_x.addr) begin
			nxt_col[NCH + int'(out_x.ch)] = 1'b1;
		end
	end

	always_comb begin
		nxt_rdata = `EDC_RST_16;
		if (reg_sel_i == `EDC_SEL_CON) begin
			nxt_rdata = con_ff[reg_ch_i];
		end else if (reg_sel_i == `EDC_SEL_REQ) begin
			nxt_rdata = {frc_ff[reg_ch_i], 8'h00, sel_ff[reg_ch_i]};
		end else if (reg_sel_i == `EDC_SEL_PRI || reg_sel_i == `EDC_SEL_SEC) begin
			nxt_rdata = ptr_ff[reg_ch_i];
		end else if (reg_sel_i == `EDC_SEL_PAD) begin
			nxt_rdata = pad_ff[reg_ch_i];
		end else if (reg_sel_i == `EDC_SEL_CNT) begin
			nxt_rdata = {6'h00, cnt_ff[reg_ch_i]};
		end else if (reg_sel_i == `EDC_SEL_COL) begin
			nxt_rdata = col_ff;
		end else begin
			nxt_rdata = {pp_ff, 4'h0, busy_o, last_ff};
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_s) begin
		if (!rst_s) begin
			for (int i = 0; i < NCH; i++) begin
				con_ff[i] <= `EDC_RST_16;
				sel_ff[i] <= 7'h00;
				pri_ff[i] <= `EDC_RST_16;
				sec_ff[i] <= `EDC_RST_16;
				pad_ff[i] <= `EDC_RST_16;
				ptr_ff[i] <= `EDC_RST_16;
				cnt_ff[i] <= 10'h000;
				idx_ff[i] <= 10'h000;
			end
			frc_ff <= '0;
			pend_ff <= '0;
			pp_ff <= '0;
			irq_ff <= '0;
			col_ff <= `EDC_RST_16;
			rdata_ff <= `EDC_RST_16;
			st_ff <= st_idle;
			ch_ff <= 3'h0;
			last_ff <= 3'h0;
			rda_ff <= `EDC_RST_16;
			dst_ff <= `EDC_RST_16;
			rdper_ff <= 1'b0;
		end else if (clk_en_i) begin
			con_ff <= nxt_con;
			sel_ff <= nxt_sel;
			pri_ff <= nxt_pri;
			sec_ff <= nxt_sec;
			pad_ff <= nxt_pad;
			ptr_ff <= nxt_ptr;
			cnt_ff <= nxt_cnt;
			idx_ff <= nxt_idx;
			frc_ff <= nxt_frc;
			pend_ff <= nxt_pend;
			pp_ff <= nxt_pp;
			irq_ff <= nxt_irq;
			col_ff <= nxt_col;
			rdata_ff <= nxt_rdata;
			st_ff <= nxt_st;
			ch_ff <= nxt_ch;
			last_ff <= nxt_last;
			rda_ff <= nxt_rda;
			dst_ff <= nxt_dst;
			rdper_ff <= nxt_rdper;
		end
	end

	// flag, enable and priority of each pulse are kept by the interrupt controller
	assign ch_irq_o = irq_ff;
	assign reg_rdata_o = rdata_ff;
	assign busy_o = (st_ff != st_idle) || b_out.valid;

	chk_arb_lowest: assert property (@(posedge sys_clk_i) disable iff (!rst_s)
		any |-> ((gnt & (gnt - 1'b1)) == '0) && ((req & (gnt - 1'b1)) == '0))
		else $error("grant not lowest requester");
	chk_read_push: assert property (@(posedge sys_clk_i) disable iff (!rst_s)
		(st_ff == st_read && clk_en_i) |=> (st_ff == st_push) && b_in.valid && b_in.ready)
		else $error("read not followed by push");
	chk_one_source: assert property (@(posedge sys_clk_i) disable iff (!rst_s)
		!(ram_rd_o && per_rd_o)) else $error("two read sources at once");
	chk_force_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_s)
		(st_ff == st_push && clk_en_i && !reg_wr_i) |=> !frc_ff[$past(ch_ff)])
		else $error("force not cleared after transfer");
	chk_irq_only_push: assert property (@(posedge sys_clk_i) disable iff (!rst_s)
		(clk_en_i && st_ff != st_push) |=> (irq_ff == '0))
		else $error("interrupt pulse outside transfer end");
	chk_byte_data: assert property (@(posedge sys_clk_i) disable iff (!rst_s)
		(b_out.valid && out_x.byte_sz) |-> (out_x.data[15:8] == 8'h00))
		else $error("byte transfer carries upper byte");
	chk_fixed_ptr: assert property (@(posedge sys_clk_i) disable iff (!rst_s)
		(st_ff == st_push && clk_en_i && !blk_end && !reg_wr_i &&
		con_ff[ch_ff][`EDC_CON_AM_HI:`EDC_CON_AM_LO] == `EDC_AM_FIX)
		|=> ptr_ff[$past(ch_ff)] == $past(ptr_ff[ch_ff]))
		else $error("fixed address pointer moved");
	chk_oneshot_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_s)
		(st_ff == st_push && clk_en_i && blk_end && !reg_wr_i &&
		con_ff[ch_ff][`EDC_CON_ONE] && !con_ff[ch_ff][`EDC_CON_PP])
		|=> !con_ff[$past(ch_ff)][`EDC_CON_EN])
		else $error("one-shot channel still enabled");
	chk_count_plus_one: assert property (@(posedge sys_clk_i) disable iff (!rst_s)
		(st_ff == st_push && clk_en_i && blk_end && !reg_wr_i) |=> idx_ff[$past(ch_ff)] == 10'h000)
		else $error("block index not restarted");
endmodule : edc_dma_top

// ### verilog/edc_params.svh
// constants of the eight-channel transfer engine: selects, field positions, reset values
// assumes inclusion by the package, by the top module and by the testbench
`ifndef EDC_PARAMS_SVH
`define EDC_PARAMS_SVH
`define EDC_NUM_CH 8
`define EDC_SRC_NUM 128
`define EDC_SEL_CON 3'h0
`define EDC_SEL_REQ 3'h1
`define EDC_SEL_PRI 3'h2
`define EDC_SEL_SEC 3'h3
`define EDC_SEL_PAD 3'h4
`define EDC_SEL_CNT 3'h5
`define EDC_SEL_COL 3'h6
`define EDC_SEL_ACT 3'h7
`define EDC_CON_EN 15
`define EDC_CON_BYTE 14
`define EDC_CON_DIR 13
`define EDC_CON_HALF 12
`define EDC_CON_AM_HI 5
`define EDC_CON_AM_LO 4
`define EDC_CON_PP 1
`define EDC_CON_ONE 0
`define EDC_CON_MASK 16'hF833
`define EDC_REQ_FORCE 15
`define EDC_AM_FIX 2'h1
`define EDC_STEP_BYTE 16'h0001
`define EDC_STEP_WORD 16'h0002
`define EDC_LOW_BYTE 16'h00FF
`define EDC_RST_16 16'h0000
// request select codes: a code is the index of the source in the request vector
`define EDC_RQ_EXT0 7'h00
`define EDC_RQ_CAP1 7'h01
`define EDC_RQ_CMP1 7'h02
`define EDC_RQ_CAP2 7'h05
`define EDC_RQ_CMP2 7'h06
`define EDC_RQ_TMR2 7'h07
`define EDC_RQ_TMR3 7'h08
`define EDC_RQ_SPI1 7'h0A
`define EDC_RQ_SER1_RX 7'h0B
`define EDC_RQ_SER1_TX 7'h0C
`define EDC_RQ_ADC 7'h0D
`define EDC_RQ_SER2_RX 7'h1E
`define EDC_RQ_SER2_TX 7'h1F
`define EDC_RQ_SPI2 7'h21
`define EDC_RQ_CAN_RX 7'h22
`define EDC_RQ_PAR 7'h2D
`define EDC_RQ_CAN_TX 7'h46
`endif

// ### verilog/edc_pkg.sv
// types of the transfer engine
// assumes edc_params.svh on the include path
`include "edc_params.svh"
package edc_pkg;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_read = 2'b01,
		st_push = 2'b11
	} edc_state_t;
	typedef struct packed {
		logic [2:0] ch;
		logic to_per;
		logic byte_sz;
		logic [15:0] addr;
		logic [15:0] data;
	} edc_xfer_t;
endpackage : edc_pkg

// ### verilog/edc_stream_if.sv
// valid/ready carrier between the engine and its buffer
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface edc_stream_if #(parameter int W = 37) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : edc_stream_if
